// ---- rtl/mcr_regs.sv ----
// Message interrupt capability registers with message write generation
//
// Overview of operation
// - Capability identifier byte in bits 7:0 is read-only and reads 05h.
// - Next pointer in bits 15:8 is read-only 00h, end of chain.
// - Enable clear means no messages; interrupts go out on legacy pin.
// - Enable set means interrupts become messages; legacy pin stays quiet.
// - Requested message count in bits 19:17 reads 000, one message.
// - Granted count bits 22:20 writable, reset 000; reserved codes are software's fault.
// - Message address bits 31:2 writable, reset zero; bits 1:0 read zero.
// - Upper message address is 32 writable bits, reset zero.
// - Message data holds 16 writable bits; upper 16 read zero.
`timescale 1ns/1ps
module mcr_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic irq_event_i,
  input wire logic msg_ready_i,
  output mcr_pkg::mcr_msg_t msg_o,
  output logic msg_valid_o,
  output logic intx_o,
  output logic msi_enabled_o
);
  import mcr_pkg::*;

  logic en_reg;
  logic [2:0] mme_reg;
  logic a64_reg;
  logic [31:2] addr_lo_reg;
  logic [31:0] addr_hi_reg;
  logic [MCR_PAYLOAD_W-1:0] payload_reg;
  logic pend_reg;
  mcr_state_t state_reg;
  logic req;
  logic wr;
  logic [31:0] rd_next;

  // Byte-lane merge of write data into an old word
  function automatic logic [31:0] mcr_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : mcr_merge

  // New request only when no ack is outstanding, so each cycle gets one ack
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;

  // Bus acknowledge, one cycle after request; unmapped addresses also acked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Control word: only enable, granted count and 64-bit bit are writable
  always_ff @(posedge clk_i) begin
    logic [31:0] m;
    m = mcr_merge({8'h00, a64_reg, mme_reg, MCR_MSG_REQ, en_reg, MCR_NEXT_PTR, MCR_CAP_ID},
                  wb_dat_i, wb_sel_i);
    if (rst_i) begin
      en_reg <= 1'b0;
      mme_reg <= MCR_MSG_RESET;
      a64_reg <= MCR_ADDR64_RESET;
    end else if (wr && wb_adr_i == MCR_OFF_CTRL) begin
      en_reg <= m[MCR_EN_BIT];
      mme_reg <= m[MCR_MME_LSB +: 3];
      a64_reg <= m[MCR_A64_BIT];
    end
  end

  // Address and data words
  always_ff @(posedge clk_i) begin
    logic [31:0] m;
    m = MCR_ZERO;
    if (rst_i) begin
      addr_lo_reg <= '0;
      addr_hi_reg <= MCR_ZERO;
      payload_reg <= '0;
    end else if (wr) begin
      unique case (wb_adr_i)
        MCR_OFF_ADDR_LO: begin
          m = mcr_merge({addr_lo_reg, MCR_ALIGN_ZERO}, wb_dat_i, wb_sel_i);
          addr_lo_reg <= m[31:2];
        end
        MCR_OFF_ADDR_HI: begin
          addr_hi_reg <= mcr_merge(addr_hi_reg, wb_dat_i, wb_sel_i);
        end
        MCR_OFF_PAYLOAD: begin
          m = mcr_merge({16'h0000, payload_reg}, wb_dat_i, wb_sel_i);
          payload_reg <= m[MCR_PAYLOAD_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_next = MCR_ZERO;
    unique case (wb_adr_i)
      MCR_OFF_CTRL: rd_next = {8'h00, a64_reg, mme_reg, MCR_MSG_REQ, en_reg,
                               MCR_NEXT_PTR, MCR_CAP_ID};
      MCR_OFF_ADDR_LO: rd_next = {addr_lo_reg, MCR_ALIGN_ZERO};
      MCR_OFF_ADDR_HI: rd_next = addr_hi_reg;
      MCR_OFF_PAYLOAD: rd_next = {16'h0000, payload_reg};
      default: rd_next = MCR_ZERO;
    endcase
  end

  // Read data registered with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= MCR_ZERO;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= rd_next;
    end
  end

  // Legacy pin follows the event only while messages are off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intx_o <= 1'b0;
      msi_enabled_o <= 1'b0;
    end else begin
      intx_o <= irq_event_i && !en_reg;
      msi_enabled_o <= en_reg;
    end
  end

  // One pending event held while a message is in flight; set wins over drain
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg) begin
      pend_reg <= 1'b0;
    end else if (irq_event_i) begin
      pend_reg <= 1'b1;
    end else if (state_reg == MCR_IDLE && pend_reg) begin
      pend_reg <= 1'b0;
    end
  end

  // Message write sequencer; contents frozen while valid stands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= MCR_IDLE;
      msg_valid_o <= 1'b0;
      msg_o <= '0;
    end else begin
      unique case (state_reg)
        MCR_IDLE: begin
          if (pend_reg && en_reg) begin
            state_reg <= MCR_SEND;
            msg_valid_o <= 1'b1;
            msg_o.addr <= {addr_hi_reg, addr_lo_reg, MCR_ALIGN_ZERO};
            msg_o.data <= {16'h0000, payload_reg};
            msg_o.wide <= addr_hi_reg != MCR_ZERO;
          end
        end
        MCR_SEND: begin
          if (msg_ready_i) begin
            state_reg <= MCR_IDLE;
            msg_valid_o <= 1'b0;
          end
        end
        default: begin
          state_reg <= MCR_IDLE;
          msg_valid_o <= 1'b0;
        end
      endcase
    end
  end
endmodule : mcr_regs

// ---- rtl/mcr_pkg.sv ----
// Package for the message interrupt capability register block
package mcr_pkg;
  // Register byte offsets
  localparam logic [7:0] MCR_OFF_CTRL = 8'hf0;
  localparam logic [7:0] MCR_OFF_ADDR_LO = 8'hf4;
  localparam logic [7:0] MCR_OFF_ADDR_HI = 8'hf8;
  localparam logic [7:0] MCR_OFF_PAYLOAD = 8'hfc;
  // Fixed field values
  localparam logic [7:0] MCR_CAP_ID = 8'h05;
  localparam logic [7:0] MCR_NEXT_PTR = 8'h00;
  localparam logic [2:0] MCR_MSG_REQ = 3'h0;
  localparam logic [2:0] MCR_MSG_RESERVED_MIN = 3'h6;
  localparam logic [2:0] MCR_MSG_RESET = 3'h0;
  localparam logic MCR_ADDR64_RESET = 1'b1;
  // Field positions in the control word
  localparam int MCR_EN_BIT = 16;
  localparam int MCR_MMC_LSB = 17;
  localparam int MCR_MME_LSB = 20;
  localparam int MCR_A64_BIT = 23;
  localparam int MCR_PAYLOAD_W = 16;
  localparam logic [31:0] MCR_ZERO = 32'h0000_0000;
  localparam logic [1:0] MCR_ALIGN_ZERO = 2'h0;

  // Outgoing interrupt message write
  typedef struct packed {
    logic [63:0] addr;
    logic [31:0] data;
    logic wide;
  } mcr_msg_t;

  // Delivery state
  typedef enum logic [1:0] {
    MCR_IDLE = 2'b00,
    MCR_SEND = 2'b01
  } mcr_state_t;
endpackage : mcr_pkg

// ---- test/mcr_host_model.sv ----
// Host side model that accepts message writes
`timescale 1ns/1ps
module mcr_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic valid_i,
  output logic ready_o,
  output logic [7:0] got_o
);
  logic [1:0] cnt_reg;
  // Slow mode takes one cycle in four, so the block must hold its write
  always_ff @(posedge clk_i) begin
    cnt_reg <= rst_i ? 2'h0 : cnt_reg + 2'h1;
  end
  assign ready_o = !slow_i || (cnt_reg == 2'h3);
  // Accepted writes
  always_ff @(posedge clk_i) begin
    got_o <= rst_i ? 8'h00 : got_o + 8'(valid_i && ready_o);
  end
endmodule : mcr_host_model

// ---- test/mcr_regs_checker.sv ----
// Assertions on the message capability register ports
`timescale 1ns/1ps
module mcr_regs_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_event_i,
  input wire logic msg_ready_i,
  input wire mcr_pkg::mcr_msg_t msg_o,
  input wire logic msg_valid_o,
  input wire logic intx_o,
  input wire logic msi_enabled_o
);
  import mcr_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answers and fixed header fields
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a one cycle answer");
  AST_HDR: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && wb_adr_i == MCR_OFF_CTRL |=> wb_dat_o[15:0] == {MCR_NEXT_PTR, MCR_CAP_ID}
    && wb_dat_o[19:17] == MCR_MSG_REQ) else $error("fixed header fields wrong");
  // Legacy pin against the enable; the enable copy shows the value the pin used
  AST_INTX_ON: assert property (irq_event_i ##1 !msi_enabled_o |-> intx_o)
    else $error("legacy interrupt missing");
  AST_INTX_OFF: assert property (msi_enabled_o |-> !intx_o)
    else $error("legacy interrupt while enabled");
  AST_NO_MSG: assert property (!msi_enabled_o && !msg_valid_o |=> !msg_valid_o)
    else $error("message while disabled");
  // Message delivery
  AST_LAT: assert property (msi_enabled_o && irq_event_i ##1 msi_enabled_o[*2]
    |-> ##[0:8] msg_valid_o) else $error("event gave no message");
  AST_HOLD: assert property (msg_valid_o && !msg_ready_i |=> msg_valid_o && $stable(msg_o))
    else $error("message dropped before acceptance");
  AST_WIDE: assert property (msg_valid_o |-> msg_o.wide == (msg_o.addr[63:32] != 0))
    else $error("wide flag wrong");
  AST_ALIGN: assert property (msg_valid_o |-> !msg_o.addr[1:0] && !msg_o.data[31:16])
    else $error("message address or data reserved bits set");
endmodule : mcr_regs_checker
bind mcr_regs mcr_regs_checker mcr_regs_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_event_i(irq_event_i),
  .msg_ready_i(msg_ready_i), .msg_o(msg_o), .msg_valid_o(msg_valid_o), .intx_o(intx_o),
  .msi_enabled_o(msi_enabled_o));

// ---- test/mcr_regs_tb.sv ----
// Self-checking bench for the message capability registers
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module mcr_regs_tb;
  import mcr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0, we = 1'b0, irq = 1'b0, slow = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] got;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rd, dat;
  logic ack, rdy, vld, intx;
  mcr_msg_t msg;
  int n_mismatch = 0;
  int n_compared = 0;
  // Offset, write value, expected read-back
  logic [71:0] rows [9] = '{{8'hf0, 32'hffdf_ffff, 32'h00d1_0005},
    {8'hf4, 32'hffff_ffff, 32'hffff_fffc}, {8'hfc, 32'hffff_ffff, 32'h0000_ffff},
    {8'he8, 32'hffff_ffff, 32'h0000_0000}, {8'hf0, 32'h0031_0000, 32'h0031_0005},
    {8'hf4, 32'h1234_5679, 32'h1234_5678}, {8'hf8, 32'hffff_ffff, 32'hffff_ffff},
    {8'hf8, 32'h0000_0000, 32'h0000_0000}, {8'hfc, 32'habcd_1357, 32'h0000_1357}};
  mcr_regs mcr_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat),
    .wb_ack_o(ack), .irq_event_i(irq), .msg_ready_i(rdy), .msg_o(msg), .msg_valid_o(vld),
    .intx_o(intx), .msi_enabled_o());
  mcr_host_model mcr_host_model_inst (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .valid_i(vld), .ready_o(rdy), .got_o(got));
  initial forever #10 clk_i = ~clk_i;
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    print_verdict();
  end
  // Single bus cycle; ack and read data taken at the rising edge that sees ack high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat;
    req <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // Event held for k cycles, then the first message is compared
  task automatic fire(input int k, input mcr_msg_t e);
    irq <= 1'b1;
    repeat (k) @(posedge clk_i);
    irq <= 1'b0;
    do @(negedge clk_i); while (vld !== 1'b1);
    `CHK(msg, e)
    @(posedge clk_i);
  endtask : fire
  task automatic print_verdict();
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wb(1'b1, rows[i][71:64], rows[i][63:32]);
      wb(1'b0, rows[i][71:64], 32'h0000_0000);
      `CHK(rd, rows[i][31:0])
    end
    fire(1, {64'h0000_0000_1234_5678, 32'h0000_1357, 1'b0});
    // Slow host and a held event: second event coalesces into one more write
    wb(1'b1, 8'hf8, 32'h0000_0001);
    slow <= 1'b1;
    fire(3, {64'h0000_0001_1234_5678, 32'h0000_1357, 1'b1});
    for (int n = 0; n < 40 && got !== 8'h03; n++) @(negedge clk_i);
    `CHK(got, 8'h03)
    @(posedge clk_i);
    wb(1'b1, 8'hf0, 32'h0000_0000);
    irq <= 1'b1;
    @(posedge clk_i);
    irq <= 1'b0;
    @(negedge clk_i);
    `CHK(intx, 1'b1)
    repeat (10) @(negedge clk_i);
    `CHK(got, 8'h03)
    // Reset in mid-run restores every register
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'hf0, 32'h0000_0000);
    `CHK(rd, 32'h0080_0005)
    for (int k = 1; k < 4; k++) begin
      wb(1'b0, 8'hf0 + 8'(4 * k), 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
    end
    print_verdict();
  end
endmodule : mcr_regs_tb
